// File: include/timer_cc_params.svh
// register indices, reset values and field positions of the timer common control block
`ifndef TIMER_CC_PARAMS_SVH
`define TIMER_CC_PARAMS_SVH

`define TCC_NCH         3
`define TCC_CNT_W       16
`define TCC_IDX_W       20
`define TCC_IDX_LSB     2
`define TCC_IDX_MSB     21
`define TCC_TOP_LSB     22

`define TCC_IDX_START   20'hfff60
`define TCC_IDX_SYNC    20'hfff61
`define TCC_IDX_MODE    20'hfff62
`define TCC_IDX_CCA     20'hfff64
`define TCC_IDX_CCB     20'hfff65
`define TCC_IDX_OVF     20'hfff66

`define TCC_RSV_START   8'hf8
`define TCC_RSV_SYNC    8'hf8
`define TCC_RSV_MODE    8'hfe
`define TCC_RSV_STAT    8'h88

`define TCC_CH_LSB      0
`define TCC_EN_LSB      4
`define TCC_PHASE_BIT   0

`define TCC_CNT_ONES    16'hffff
`define TCC_CNT_ZERO    16'h0000

`endif

// File: include/timer_cc_pkg.sv
// state types of the timer common control block
package timer_cc_pkg;

    typedef struct packed {
        logic [2:0]  run;
        logic [2:0]  sync;
        logic        phase;
        logic [2:0]  en_a;
        logic [2:0]  en_b;
        logic [2:0]  en_wrap;
        logic        wr_pend;
        logic [19:0] wr_idx;
        logic [31:0] rdata;
    } ctrl_state_t;

    typedef struct packed {
        logic [2:0] flag;
        logic [2:0] armed;
    } flag_state_t;

    typedef struct packed {
        logic [15:0] prev;
        logic        seen;
    } event_state_t;

endpackage

// File: src/channel_event_detect.sv
// compare match, capture and wrap detection for one timer channel
`timescale 1ns/1ns
`default_nettype none
`include "timer_cc_params.svh"

module channel_event_detect #(
    parameter int W         = `TCC_CNT_W,
    parameter bit UNDERFLOW = 1'b0
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    // channel state
    input  wire logic [W-1:0] i_count,
    input  wire logic [W-1:0] i_general_a,
    input  wire logic [W-1:0] i_general_b,
    input  wire logic         i_a_capture_mode,
    input  wire logic         i_b_capture_mode,
    input  wire logic         i_capture_a,
    input  wire logic         i_capture_b,
    // event pulses
    output logic              o_set_a,
    output logic              o_set_b,
    output logic              o_wrap
);

    timer_cc_pkg::event_state_t st;
    timer_cc_pkg::event_state_t next_st;
    logic                       moved;

    initial
    begin
        if (W != `TCC_CNT_W)
            $error("counter width must match the state type");
    end

    // a halted counter sitting on the compare value must not re-fire every cycle
    always_comb
    begin
        next_st      = st;
        next_st.prev = i_count;
        next_st.seen = 1'b1;
        moved        = st.seen && (i_count != st.prev);
        o_set_a = i_a_capture_mode ? i_capture_a
                                   : (moved && i_count == i_general_a);
        o_set_b = i_b_capture_mode ? i_capture_b
                                   : (moved && i_count == i_general_b);
        o_wrap  = st.seen && st.prev == `TCC_CNT_ONES
                  && i_count == `TCC_CNT_ZERO;
        if (UNDERFLOW && st.seen && st.prev == `TCC_CNT_ZERO
            && i_count == `TCC_CNT_ONES)
            o_wrap = 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            st <= '0;
        else
            st <= next_st;
    end

endmodule
`default_nettype wire

// File: src/flag_bank.sv
// three status flags with read-then-write-zero clearing
`timescale 1ns/1ns
`default_nettype none
`include "timer_cc_params.svh"

module flag_bank #(
    parameter int N = `TCC_NCH
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    // hardware set events
    input  wire logic [N-1:0] i_set,
    // bus side
    input  wire logic         i_read,
    input  wire logic         i_write,
    input  wire logic [N-1:0] i_wdata,
    // flags
    output logic [N-1:0]      o_flag
);

    timer_cc_pkg::flag_state_t st;
    timer_cc_pkg::flag_state_t next_st;
    logic [N-1:0]              arm;
    logic [N-1:0]              clr;

    initial
    begin
        if (N != `TCC_NCH)
            $error("flag count must match the state type");
    end

    always_comb
    begin
        next_st = st;
        arm     = st.armed | (i_read ? st.flag : '0);
        // only a zero written to a flag seen as one clears it; a one never sets
        clr     = i_write ? (~i_wdata & st.armed & st.flag) : '0;
        next_st.flag  = (st.flag & ~clr) | i_set;
        next_st.armed = arm & ~clr & next_st.flag;
        o_flag  = st.flag;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            st <= '0;
        else
            st <= next_st;
    end

endmodule
`default_nettype wire

// File: src/timer_common_control.sv
// common start, synchronisation, mode and status logic of the three timer channels
`timescale 1ns/1ns
`default_nettype none
`include "timer_cc_params.svh"

// Contract
// - start bit 0 halts its counter, 1 lets it count; all zero after reset
// - phase select 1 puts channel 2 into phase counting; 0 after reset
// - flag A sets when counter equals general A in compare mode
// - flag A sets when a capture loads general A in capture mode
// - flag clears only by reading it as one, then writing zero
// - writing one never sets a flag; only hardware events set them
// - request A active only while flag A and enable A; enable resets 0
// - request B active only while flag B and enable B; enable resets 0
// - overflow flag sets when a counter wraps from all ones to zero
// - channel 2 overflow flag also sets on underflow zero to all ones
// - overflow flag clears only by reading it as one, then writing zero
// - overflow request active only while flag and enable; enable resets 0
// - overflow register bits 7 and 3 read one; enables 6..4, flags 2..0
// - a channel selecting synchronous clear clears with the other synced channels
module timer_common_control #(
    parameter int NCH = `TCC_NCH,
    parameter int W   = `TCC_CNT_W
) (
    // clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_arst_n,
    // ahb-lite slave
    input  wire logic                i_hsel,
    input  wire logic [31:0]         i_haddr,
    input  wire logic [1:0]          i_htrans,
    input  wire logic                i_hwrite,
    input  wire logic [2:0]          i_hsize,
    input  wire logic [31:0]         i_hwdata,
    input  wire logic                i_hready,
    output logic                     o_hreadyout,
    output logic                     o_hresp,
    output logic [31:0]              o_hrdata,
    // channel state
    input  wire logic [NCH-1:0][W-1:0] i_count,
    input  wire logic [NCH-1:0][W-1:0] i_general_a,
    input  wire logic [NCH-1:0][W-1:0] i_general_b,
    input  wire logic [NCH-1:0]      i_a_capture_mode,
    input  wire logic [NCH-1:0]      i_b_capture_mode,
    input  wire logic [NCH-1:0]      i_capture_a,
    input  wire logic [NCH-1:0]      i_capture_b,
    // synchronisation sources
    input  wire logic [NCH-1:0]      i_clear_source,
    input  wire logic [NCH-1:0]      i_preset_source,
    input  wire logic [NCH-1:0]      i_sync_clear_select,
    // channel control
    output logic [NCH-1:0]           o_count_run,
    output logic [NCH-1:0]           o_sync_join,
    output logic                     o_phase_mode,
    output logic [NCH-1:0]           o_sync_clear,
    output logic [NCH-1:0]           o_sync_preset,
    // status flags
    output logic [NCH-1:0]           o_match_a_flag,
    output logic [NCH-1:0]           o_match_b_flag,
    output logic [NCH-1:0]           o_wrap_flag,
    // interrupt requests
    output logic [NCH-1:0]           o_match_a_request,
    output logic [NCH-1:0]           o_match_b_request,
    output logic [NCH-1:0]           o_wrap_request
);

    timer_cc_pkg::ctrl_state_t st;
    timer_cc_pkg::ctrl_state_t next_st;

    // event pulses from the channel detectors
    logic [NCH-1:0] set_a;
    logic [NCH-1:0] set_b;
    logic [NCH-1:0] set_wrap;

    // bus decode
    logic           accept;
    logic [19:0]    acc_idx;
    logic           rd_a;
    logic           rd_b;
    logic           rd_ovf;
    logic           wr_a;
    logic           wr_b;
    logic           wr_ovf;
    logic [7:0]     wbyte;

    // synchronisation fan-out
    logic           any_clear;
    logic           any_preset;

    initial
    begin
        if (NCH != `TCC_NCH || W != `TCC_CNT_W)
            $error("channel count and width are fixed by the register layout");
        if (`TCC_IDX_MSB - `TCC_IDX_LSB + 1 != `TCC_IDX_W)
            $error("index field width disagrees with its bounds");
        if (`TCC_TOP_LSB != `TCC_IDX_MSB + 1)
            $error("address bits above the index must start right after it");
    end

    // word index of an address; upper bits must be zero for a hit
    function automatic logic [19:0] index_of(input logic [31:0] addr);
        index_of = addr[`TCC_IDX_MSB:`TCC_IDX_LSB];
    endfunction

    function automatic logic mapped(input logic [31:0] addr);
        logic [19:0] idx;
        idx    = index_of(addr);
        mapped = (addr[31:`TCC_TOP_LSB] == '0)
                 && (idx == `TCC_IDX_START
                     || idx == `TCC_IDX_SYNC
                     || idx == `TCC_IDX_MODE
                     || idx == `TCC_IDX_CCA
                     || idx == `TCC_IDX_CCB
                     || idx == `TCC_IDX_OVF);
    endfunction

    // read taken in this address phase that targets one register
    function automatic logic read_hit(input logic        take,
                                      input logic        wr,
                                      input logic [31:0] addr,
                                      input logic [19:0] idx);
        read_hit = take && !wr && mapped(addr) && index_of(addr) == idx;
    endfunction

    // write to one register whose data phase is under way
    function automatic logic write_hit(input logic        pend,
                                       input logic [19:0] pend_idx,
                                       input logic [19:0] idx);
        write_hit = pend && pend_idx == idx;
    endfunction

    // status layout: enables in 6..4, flags in 2..0, reserved bits read one
    function automatic logic [7:0] status_byte(input logic [2:0] en,
                                               input logic [2:0] flag);
        status_byte = `TCC_RSV_STAT;
        status_byte[`TCC_EN_LSB +: 3] = en;
        status_byte[`TCC_CH_LSB +: 3] = flag;
    endfunction

    function automatic logic [7:0] read_byte(input logic [19:0] idx,
                                             input timer_cc_pkg::ctrl_state_t s,
                                             input logic [2:0] fa,
                                             input logic [2:0] fb,
                                             input logic [2:0] fw);
        read_byte = 8'h00;
        case (idx)
            `TCC_IDX_START: read_byte = `TCC_RSV_START | {5'h00, s.run};
            `TCC_IDX_SYNC:  read_byte = `TCC_RSV_SYNC | {5'h00, s.sync};
            `TCC_IDX_MODE:  read_byte = `TCC_RSV_MODE | {7'h00, s.phase};
            `TCC_IDX_CCA:   read_byte = status_byte(s.en_a, fa);
            `TCC_IDX_CCB:   read_byte = status_byte(s.en_b, fb);
            `TCC_IDX_OVF:   read_byte = status_byte(s.en_wrap, fw);
            default:        read_byte = 8'h00;
        endcase
    endfunction

    // one detector per channel; only channel 2 counts down, so only it flags underflow
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++)
        begin : g_ch
            channel_event_detect #(
                .W         (W),
                .UNDERFLOW (ch == 2)
            ) u_detect (
                .i_clk            (i_clk),
                .i_arst_n         (i_arst_n),
                .i_count          (i_count[ch]),
                .i_general_a      (i_general_a[ch]),
                .i_general_b      (i_general_b[ch]),
                .i_a_capture_mode (i_a_capture_mode[ch]),
                .i_b_capture_mode (i_b_capture_mode[ch]),
                .i_capture_a      (i_capture_a[ch]),
                .i_capture_b      (i_capture_b[ch]),
                .o_set_a          (set_a[ch]),
                .o_set_b          (set_b[ch]),
                .o_wrap           (set_wrap[ch])
            );
        end
    endgenerate

    // a read arms its flags on the address-phase edge, the same edge that latches hrdata
    always_comb
    begin
        accept  = i_hsel && i_htrans[1] && i_hready;
        acc_idx = index_of(i_haddr);
        rd_a    = read_hit(accept, i_hwrite, i_haddr, `TCC_IDX_CCA);
        rd_b    = read_hit(accept, i_hwrite, i_haddr, `TCC_IDX_CCB);
        rd_ovf  = read_hit(accept, i_hwrite, i_haddr, `TCC_IDX_OVF);

        // a write clears at the data-phase edge, when hwdata stands
        wr_a    = write_hit(st.wr_pend, st.wr_idx, `TCC_IDX_CCA);
        wr_b    = write_hit(st.wr_pend, st.wr_idx, `TCC_IDX_CCB);
        wr_ovf  = write_hit(st.wr_pend, st.wr_idx, `TCC_IDX_OVF);

        // only the low byte lane carries register data
        wbyte   = i_hwdata[7:0];
    end

    // flag a: compare match or capture into general a
    flag_bank #(.N(NCH)) u_flags_a (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_set    (set_a),
        .i_read   (rd_a),
        .i_write  (wr_a),
        .i_wdata  (wbyte[`TCC_CH_LSB +: 3]),
        .o_flag   (o_match_a_flag)
    );

    // flag b: compare match or capture into general b
    flag_bank #(.N(NCH)) u_flags_b (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_set    (set_b),
        .i_read   (rd_b),
        .i_write  (wr_b),
        .i_wdata  (wbyte[`TCC_CH_LSB +: 3]),
        .o_flag   (o_match_b_flag)
    );

    // overflow flags; channel 2 also flags underflow
    flag_bank #(.N(NCH)) u_flags_wrap (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_set    (set_wrap),
        .i_read   (rd_ovf),
        .i_write  (wr_ovf),
        .i_wdata  (wbyte[`TCC_CH_LSB +: 3]),
        .o_flag   (o_wrap_flag)
    );

    always_comb
    begin
        next_st = st;
        if (st.wr_pend)
        begin
            case (st.wr_idx)
                `TCC_IDX_START: next_st.run     = wbyte[`TCC_CH_LSB +: 3];
                `TCC_IDX_SYNC:  next_st.sync    = wbyte[`TCC_CH_LSB +: 3];
                `TCC_IDX_MODE:  next_st.phase   = wbyte[`TCC_PHASE_BIT];
                `TCC_IDX_CCA:   next_st.en_a    = wbyte[`TCC_EN_LSB +: 3];
                `TCC_IDX_CCB:   next_st.en_b    = wbyte[`TCC_EN_LSB +: 3];
                `TCC_IDX_OVF:   next_st.en_wrap = wbyte[`TCC_EN_LSB +: 3];
                default:        next_st.run     = st.run;
            endcase
        end

        // unmapped writes are dropped here, so they never reach a register
        next_st.wr_pend = accept && i_hwrite && mapped(i_haddr);
        next_st.wr_idx  = acc_idx;

        // zero wait states: read data is latched at the address-phase edge, so a read
        // straight behind a write to the same register still shows the old value
        if (accept && !i_hwrite)
        begin
            next_st.rdata = {24'h000000,
                             read_byte(acc_idx,
                                       st,
                                       o_match_a_flag,
                                       o_match_b_flag,
                                       o_wrap_flag)};
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            st <= '0;
        else
            st <= next_st;
    end

    // a clear or preset from any joined channel is shared by all joined channels;
    // the clear only reaches channels whose clear select asks for it
    always_comb
    begin
        any_clear     = |(i_clear_source & st.sync);
        any_preset    = |(i_preset_source & st.sync);

        o_sync_clear  = (any_clear ? st.sync : '0) & i_sync_clear_select;
        o_sync_preset = any_preset ? st.sync : '0;
    end

    // never stalls and never errors, so hready and hresp are constant
    assign o_hreadyout       = 1'b1;
    assign o_hresp           = 1'b0;
    assign o_hrdata          = st.rdata;

    // channel control levels, straight from the registers
    assign o_count_run       = st.run;
    assign o_sync_join       = st.sync;
    assign o_phase_mode      = st.phase;

    // a request needs both its flag and its enable
    assign o_match_a_request = o_match_a_flag & st.en_a;
    assign o_match_b_request = o_match_b_flag & st.en_b;
    assign o_wrap_request    = o_wrap_flag & st.en_wrap;

endmodule
`default_nettype wire

// File: tb/timer_common_control_asserts.sv
// concurrent checks on the ports of the timer common control block
`timescale 1ns/1ns
`default_nettype none
module timer_common_control_asserts #(
    parameter int NCH = 3,
    parameter int W   = 16
) (
    // clock, reset and bus
    input wire logic                  i_clk,
    input wire logic                  i_arst_n,
    input wire logic                  i_hsel,
    input wire logic [1:0]            i_htrans,
    input wire logic                  i_hwrite,
    input wire logic                  i_hready,
    // channel side
    input wire logic [NCH-1:0][W-1:0] i_count,
    input wire logic [NCH-1:0][W-1:0] i_general_a,
    input wire logic [NCH-1:0]        i_a_capture_mode,
    input wire logic [NCH-1:0]        i_capture_a,
    input wire logic [NCH-1:0]        i_clear_source,
    input wire logic [NCH-1:0]        i_sync_clear_select,
    // watched outputs
    input wire logic [NCH-1:0]        o_count_run,
    input wire logic [NCH-1:0]        o_sync_join,
    input wire logic                  o_phase_mode,
    input wire logic [NCH-1:0]        o_sync_clear,
    input wire logic [NCH-1:0]        o_match_a_flag,
    input wire logic [NCH-1:0]        o_match_b_flag,
    input wire logic [NCH-1:0]        o_wrap_flag,
    input wire logic [NCH-1:0]        o_match_a_request,
    input wire logic [NCH-1:0]        o_match_b_request,
    input wire logic [NCH-1:0]        o_wrap_request
);
    // a write taken here clears armed flags one edge later, at the edge ending its data phase
    wire logic wr_take = i_hsel && i_htrans[1] && i_hwrite && i_hready;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    a_reset_ctrl_idle: assert property (!$past(i_arst_n) |->
        o_count_run == '0 && o_sync_join == '0 && !o_phase_mode)
        else $error("control outputs not idle after reset");
    a_req_a_gated: assert property ((o_match_a_request & ~o_match_a_flag) == '0)
        else $error("request a without flag a");
    a_req_b_gated: assert property ((o_match_b_request & ~o_match_b_flag) == '0)
        else $error("request b without flag b");
    a_req_wrap_gated: assert property ((o_wrap_request & ~o_wrap_flag) == '0)
        else $error("wrap request without wrap flag");
    a_cmp_sets_a: assert property (!i_a_capture_mode[0] && i_count[0] == i_general_a[0]
        && i_count[0] != $past(i_count[0]) |=> o_match_a_flag[0])
        else $error("compare match did not set flag a");
    a_cap_sets_a: assert property (i_a_capture_mode[1] && i_capture_a[1]
        |=> o_match_a_flag[1]) else $error("capture did not set flag a");
    a_wrap_sets_flag: assert property ($past(i_count[0]) == 16'hffff
        && i_count[0] == 16'h0000 |=> o_wrap_flag[0]) else $error("wrap missed");
    a_under_sets_flag: assert property ($past(i_count[2]) == 16'h0000
        && i_count[2] == 16'hffff |=> o_wrap_flag[2]) else $error("underflow missed");
    a_no_false_set: assert property (!o_wrap_flag[1] && !($past(i_count[1]) == 16'hffff
        && i_count[1] == 16'h0000) |=> !o_wrap_flag[1]) else $error("wrap flag set uncaused");
    a_flag_holds: assert property (o_wrap_flag[1] && !wr_take
        |=> o_wrap_flag[1]) else $error("wrap flag cleared without write");
    a_sync_clear_fan: assert property (o_sync_clear == (o_sync_join & i_sync_clear_select
        & {NCH{|(i_clear_source & o_sync_join)}})) else $error("sync clear fan-out wrong");

    c_request_a: cover property ($rose(o_match_a_request[0]));
    c_wrap_clear: cover property ($fell(o_wrap_flag[0]));
    c_sync_clear: cover property (|o_sync_clear);
endmodule

bind timer_common_control timer_common_control_asserts #(.NCH(NCH), .W(W)) u_chk (
    .i_clk, .i_arst_n, .i_hsel, .i_htrans, .i_hwrite, .i_hready, .i_count, .i_general_a,
    .i_a_capture_mode, .i_capture_a, .i_clear_source, .i_sync_clear_select, .o_count_run,
    .o_sync_join, .o_phase_mode, .o_sync_clear, .o_match_a_flag, .o_match_b_flag,
    .o_wrap_flag, .o_match_a_request, .o_match_b_request, .o_wrap_request
);
`default_nettype wire

// File: tb/tb_timer_common_control.sv
// self-checking bench of the timer common control block
`timescale 1ns/1ns
`default_nettype none
`include "timer_cc_params.svh"
module tb_timer_common_control;
    logic             i_clk = 1'h0;
    logic             i_arst_n = 1'h0;
    logic             i_hsel = 1'h0;
    logic [31:0]      i_haddr = 32'h0;
    logic [1:0]       i_htrans = 2'h0;
    logic             i_hwrite = 1'h0;
    logic [2:0]       i_hsize = 3'h2;
    logic [31:0]      i_hwdata = 32'h0;
    logic [2:0][15:0] i_count = '0;
    logic [2:0][15:0] i_general_a = '0;
    logic [2:0][15:0] i_general_b = {3{16'h8000}};
    logic [2:0]       i_a_capture_mode = 3'h0, i_b_capture_mode = 3'h0;
    logic [2:0]       i_capture_a = 3'h0, i_capture_b = 3'h0, i_clear_source = 3'h0;
    logic [2:0]       i_preset_source = 3'h0, i_sync_clear_select = 3'h0;
    logic             o_hreadyout, o_hresp, o_phase_mode;
    logic [31:0]      o_hrdata, rd;
    logic [2:0]       o_count_run, o_sync_join, o_sync_clear, o_sync_preset;
    logic [2:0]       o_match_a_flag, o_match_b_flag, o_wrap_flag;
    logic [2:0]       o_match_a_request, o_match_b_request, o_wrap_request;
    logic [2:0]       en [3];
    logic [19:0]      sidx [3];
    logic [15:0]      g;
    logic [7:0]       v;
    int               seed = 32'hb26e;
    int               n_fail = 0;
    int               checked = 0;
    wire logic        i_hready = o_hreadyout;

    always #20 i_clk = ~i_clk;

    timer_common_control u_dut (
        .i_clk, .i_arst_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
        .i_hready, .o_hreadyout, .o_hresp, .o_hrdata, .i_count, .i_general_a, .i_general_b,
        .i_a_capture_mode, .i_b_capture_mode, .i_capture_a, .i_capture_b, .i_clear_source,
        .i_preset_source, .i_sync_clear_select, .o_count_run, .o_sync_join, .o_phase_mode,
        .o_sync_clear, .o_sync_preset, .o_match_a_flag, .o_match_b_flag, .o_wrap_flag,
        .o_match_a_request, .o_match_b_request, .o_wrap_request
    );

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, e, s);
        end
    endtask

    task automatic chk3(input string name, input logic [2:0] e, input logic [2:0] s);
        check(name, {29'h0, e}, {29'h0, s});
    endtask

    // address phase, then data phase; each waits for hready under a bound
    task automatic bus(input logic wr, input logic [19:0] idx, input logic [7:0] wd);
        int n;
        i_hsel <= 1'h1;
        i_htrans <= 2'h2;
        i_haddr <= {10'h0, idx, 2'h0};
        i_hwrite <= wr;
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            do
            begin
                @(posedge i_clk);
                n++;
            end
            while (i_hready !== 1'h1 && n < 50);
            if (n >= 50)
            begin
                n_fail++;
                complete_run();
            end
            if (k == 0)
            begin
                i_htrans <= 2'h0;
                i_hwdata <= {24'h0, wd};
            end
        end
        rd = o_hrdata;
        check("hresp", 32'h0, {31'h0, o_hresp});
    endtask

    task automatic rchk(input string name, input logic [19:0] idx, input logic [7:0] e);
        bus(1'h0, idx, 8'h0);
        check(name, {24'h0, e}, rd);
    endtask

    function automatic logic [7:0] stat(input logic [2:0] en_v, input logic [2:0] f);
        return {1'h1, en_v, 1'h1, f};
    endfunction

    initial
    begin
        sidx = '{`TCC_IDX_CCA, `TCC_IDX_CCB, `TCC_IDX_OVF};
        repeat (4)
            @(posedge i_clk);
        i_arst_n <= 1'h1;
        @(posedge i_clk);
        rchk("start", `TCC_IDX_START, 8'hf8);
        rchk("sync", `TCC_IDX_SYNC, 8'hf8);
        rchk("mode", `TCC_IDX_MODE, 8'hfe);
        rchk("unmapped", 20'hfff63, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            rchk("status reset", sidx[i], 8'h88);
            // ch0 enabled and ch1 masked so both gating cases appear
            en[i] = {1'($random(seed)), 2'h1};
            bus(1'h1, sidx[i], stat(en[i], 3'h7));
            rchk("status", sidx[i], stat(en[i], 3'h0));
        end
        repeat (8)
        begin
            v = 8'($random(seed));
            bus(1'h1, `TCC_IDX_START, v);
            bus(1'h1, `TCC_IDX_SYNC, ~v);
            bus(1'h1, `TCC_IDX_MODE, {7'h0, v[3]});
            #1;
            chk3("run", v[2:0], o_count_run);
            chk3("join", ~v[2:0], o_sync_join);
            chk3("phase", {2'h0, v[3]}, {2'h0, o_phase_mode});
            rchk("start", `TCC_IDX_START, {5'h1f, v[2:0]});
            rchk("mode", `TCC_IDX_MODE, {7'h7f, v[3]});
        end
        // below bit 15 so neither general b nor a wrap is hit by the walk
        g = {1'h0, 15'($random(seed))} | 16'h0100;
        @(posedge i_clk);
        i_general_a[0] <= g;
        i_count <= {16'hffff, 16'hffff, g - 16'h0001};
        i_a_capture_mode <= 3'h2;
        i_b_capture_mode <= 3'h4;
        @(posedge i_clk);
        i_count[0] <= g;
        i_capture_a <= 3'h2;
        i_capture_b <= 3'h4;
        @(posedge i_clk);
        i_capture_a <= 3'h0;
        i_capture_b <= 3'h0;
        i_count <= {16'hffff, 16'h0000, 16'hffff};
        #1;
        chk3("flag a", 3'h3, o_match_a_flag);
        chk3("flag b", 3'h4, o_match_b_flag);
        chk3("wrap flag", 3'h4, o_wrap_flag);
        chk3("request a", 3'h3 & en[0], o_match_a_request);
        chk3("request b", 3'h4 & en[1], o_match_b_request);
        @(posedge i_clk);
        i_count[0] <= 16'h0000;
        @(posedge i_clk);
        #1;
        chk3("wrap flag", 3'h7, o_wrap_flag);
        bus(1'h1, `TCC_IDX_OVF, stat(en[2], 3'h0));
        #1;
        chk3("wrap flag", 3'h7, o_wrap_flag);
        rchk("overflow", `TCC_IDX_OVF, stat(en[2], 3'h7));
        bus(1'h1, `TCC_IDX_OVF, stat(en[2], 3'h6));
        #1;
        chk3("wrap flag", 3'h6, o_wrap_flag);
        chk3("wrap request", 3'h6 & en[2], o_wrap_request);
        rchk("status a", `TCC_IDX_CCA, stat(en[0], 3'h3));
        fork
            bus(1'h1, `TCC_IDX_CCA, stat(en[0], 3'h0));
            begin
                @(posedge i_clk);
                i_capture_a <= 3'h2;
                @(posedge i_clk);
                i_capture_a <= 3'h0;
            end
        join
        #1;
        chk3("flag a", 3'h2, o_match_a_flag);
        bus(1'h1, `TCC_IDX_CCA, stat(en[0], 3'h0));
        #1;
        chk3("flag a", 3'h2, o_match_a_flag);
        rchk("status b", `TCC_IDX_CCB, stat(en[1], 3'h4));
        bus(1'h1, `TCC_IDX_CCB, stat(en[1], 3'h0));
        #1;
        chk3("flag b", 3'h0, o_match_b_flag);
        bus(1'h1, `TCC_IDX_SYNC, 8'h03);
        @(posedge i_clk);
        i_sync_clear_select <= 3'h5;
        i_clear_source <= 3'h1;
        i_preset_source <= 3'h4;
        #1;
        chk3("sync clear", 3'h1, o_sync_clear);
        chk3("sync preset", 3'h0, o_sync_preset);
        @(posedge i_clk);
        i_clear_source <= 3'h4;
        i_preset_source <= 3'h2;
        #1;
        chk3("sync clear", 3'h0, o_sync_clear);
        chk3("sync preset", 3'h3, o_sync_preset);
        @(posedge i_clk);
        i_clear_source <= 3'h0;
        i_preset_source <= 3'h0;
        complete_run();
    end
endmodule
`default_nettype wire
